//--- hdl/zli_consts.svh
// Purpose: named offsets, field positions and fixed values for the insertion framer
// Assumes: 8-bit register addresses, 32-bit register data
// Notes: included by the framer and the bench
`ifndef ZLI_CONSTS_SVH
`define ZLI_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ZLI_A_CMD 8'h00
`define ZLI_A_MSG 8'h04
`define ZLI_A_TSLO 8'h08
`define ZLI_A_TSHI 8'h0C
`define ZLI_A_LEAD 8'h10
`define ZLI_A_SEQ 8'h14
`define ZLI_A_STAT 8'h18
`define ZLI_A_REJ 8'h1C
`define ZLI_A_SESS 8'h20

// ----------------------------------------------------------------
// command bits and fields
// ----------------------------------------------------------------
`define ZLI_CMD_PUSH 0
`define ZLI_CMD_SEND 1
`define ZLI_CMD_CLR 2
`define ZLI_SEQ_ON_BIT 16
`define ZLI_STAT_BUSY 8
`define ZLI_STAT_FULL 9

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define ZLI_HDR_LAST 4'h3
`define ZLI_MSG_LAST 4'hB
`define ZLI_HDR_BYTES 16'h0004
`define ZLI_MSG_BYTES 16'h000C
`define ZLI_HDR_VCCV 1'b0
`define ZLI_HDR_EXT 2'b00
`define ZLI_HDR_FLOW 3'b000
`define ZLI_HDR_RSV 1'b0
`define ZLI_MSG_RSV 16'h0000
`define ZLI_NUMSYM_MIN 8'h01
`define ZLI_SESS_RST 16'h0000
`define ZLI_LEAD_RST 32'h0000_0000

`endif

//--- hdl/zli_pkg.sv
// Purpose: types shared by the insertion framer
// Assumes: zli_consts.svh holds the numbers
// Notes: one staged message travels as zli_msg_t
package zli_pkg;

   typedef struct packed {
      logic [7:0] chan;
      logic [7:0] numSym;
      logic [63:0] startTs;
   } zli_msg_t;

   typedef enum logic [1:0] {
      ZLI_IDLE,
      ZLI_HDR,
      ZLI_BODY
   } zli_state_t;

endpackage

//--- hdl/zli_framer.sv
// Purpose: controller-side framer for zero-load insertion packets
// Assumes: tsNow is the local timestamp on sys_clk; seed comes from software
// Notes: byte stream out, one packet per send command, no gaps inside a packet
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "zli_consts.svh"

module zli_framer
   import zli_pkg::*;
#(
   parameter int MSG_MAX = 16,
   parameter int N_CHAN = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // software register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // local timestamp
   input wire logic [63:0] tsNow,
   // packet byte stream to the pseudowire session
   output logic [7:0] txData,
   output logic txValid,
   output logic txLast,
   input wire logic txReady,
   output logic [15:0] txSession
);

   localparam int CW = $clog2(MSG_MAX + 1);
   localparam int IW = (MSG_MAX > 1) ? $clog2(MSG_MAX) : 1;
   localparam int HW = (N_CHAN > 1) ? $clog2(N_CHAN) : 1;

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (MSG_MAX < 1 || MSG_MAX > 127 || N_CHAN < 1 || N_CHAN > 256) begin : g_badParam
      $error("zli_framer: MSG_MAX must be 1..127 and N_CHAN 1..256");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   zli_msg_t q_r [MSG_MAX];
   logic [63:0] lastTs_r [N_CHAN];
   zli_state_t state_r;
   logic [CW-1:0] cnt_r;
   logic [IW-1:0] msgIdx_r;
   logic [3:0] byteIdx_r;
   logic [15:0] msgA_r;
   logic [31:0] tsLo_r;
   logic [31:0] tsHi_r;
   logic [31:0] lead_r;
   logic [15:0] seq_r;
   logic seqOn_r;
   logic [31:0] rej_r;
   logic [15:0] sess_r;
   logic [31:0] rdata_r;
   logic [15:0] pktBytes_r;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire busy = (state_r != ZLI_IDLE);
   wire full = (cnt_r == CW'(MSG_MAX));
   wire cmdWr = regWr && (regAddr == `ZLI_A_CMD);
   wire pushReq = cmdWr && regWdata[`ZLI_CMD_PUSH];
   wire sendReq = cmdWr && regWdata[`ZLI_CMD_SEND] && !busy && (cnt_r != '0);
   wire clrReq = cmdWr && regWdata[`ZLI_CMD_CLR] && !busy;
   wire [63:0] pushTs = {tsHi_r, tsLo_r};
   wire [7:0] pushChan = msgA_r[7:0];
   wire [7:0] pushSym = msgA_r[15:8];
   // nine bits so that a full set of 256 channels still compares correctly
   wire chanOk = ({1'b0, pushChan} < 9'(N_CHAN));
   wire [HW-1:0] chanIdx = HW'(pushChan);
   wire [63:0] chanLast = chanOk ? lastTs_r[chanIdx] : 64'h0000_0000_0000_0000;
   wire [63:0] earliest = tsNow + {32'h0000_0000, lead_r};
   wire leadOk = (pushTs >= earliest);
   wire orderOk = (pushTs >= chanLast);
   wire symOk = (pushSym >= `ZLI_NUMSYM_MIN);
   wire pushOk = pushReq && !busy && !full && chanOk && leadOk && orderOk && symOk;
   wire pushBad = pushReq && !pushOk;

   // ----------------------------------------------------------------
   // frame bytes
   // ----------------------------------------------------------------
   // header: VCCV, seq-valid, ext header, flow selector, pad; reserved + count; sequence
   wire [31:0] hdrWord = {`ZLI_HDR_VCCV, seqOn_r, `ZLI_HDR_EXT, `ZLI_HDR_FLOW,
                          `ZLI_HDR_RSV, `ZLI_HDR_RSV, 7'(cnt_r), seq_r};
   wire zli_msg_t curMsg = q_r[msgIdx_r];
   wire [95:0] msgBits = {curMsg.chan, curMsg.numSym, curMsg.startTs, `ZLI_MSG_RSV};
   wire [6:0] hdrBase = 7'(5'd24 - {byteIdx_r[2:0], 3'b000});
   wire [6:0] msgBase = 7'(7'd88 - {byteIdx_r, 3'b000});
   wire [7:0] hdrByte = hdrWord[hdrBase[4:0] +: 8];
   wire [7:0] msgByte = msgBits[msgBase +: 8];
   wire lastMsg = (CW'(msgIdx_r) == CW'(cnt_r - 1'b1));
   wire step = txValid && txReady;
   wire hdrEnd = (state_r == ZLI_HDR) && (byteIdx_r == `ZLI_HDR_LAST);
   wire msgEnd = (state_r == ZLI_BODY) && (byteIdx_r == `ZLI_MSG_LAST);

   assign txValid = busy;
   assign txData = (state_r == ZLI_HDR) ? hdrByte : msgByte;
   assign txLast = msgEnd && lastMsg;
   assign txSession = sess_r;
   assign regRdata = rdata_r;

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   // once started, a packet runs to its last byte with no idle cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= ZLI_IDLE;
         byteIdx_r <= 4'h0;
         msgIdx_r <= '0;
      end else begin
         unique case (state_r)
            ZLI_IDLE: begin
               if (sendReq) begin
                  state_r <= ZLI_HDR;
                  byteIdx_r <= 4'h0;
                  msgIdx_r <= '0;
               end
            end
            ZLI_HDR: begin
               if (step) begin
                  byteIdx_r <= hdrEnd ? 4'h0 : byteIdx_r + 4'h1;
                  if (hdrEnd) begin
                     state_r <= ZLI_BODY;
                  end
               end
            end
            ZLI_BODY: begin
               if (step) begin
                  byteIdx_r <= msgEnd ? 4'h0 : byteIdx_r + 4'h1;
                  if (msgEnd) begin
                     msgIdx_r <= msgIdx_r + 1'b1;
                     if (lastMsg) begin
                        state_r <= ZLI_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // staging queue
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (clrReq || (step && txLast)) begin
         cnt_r <= '0;
      end else if (pushOk) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (pushOk) begin
         q_r[IW'(cnt_r)] <= '{chan: pushChan, numSym: pushSym, startTs: pushTs};
      end
   end

   // newest start time per channel keeps later pushes in order
   for (genvar c = 0; c < N_CHAN; c++) begin : g_chan
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            lastTs_r[c] <= 64'h0000_0000_0000_0000;
         end else if (pushOk && chanIdx == HW'(c)) begin
            lastTs_r[c] <= pushTs;
         end
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         msgA_r <= 16'h0000;
         tsLo_r <= 32'h0000_0000;
         tsHi_r <= 32'h0000_0000;
         lead_r <= `ZLI_LEAD_RST;
         sess_r <= `ZLI_SESS_RST;
      end else if (regWr) begin
         if (regAddr == `ZLI_A_MSG) msgA_r <= regWdata[15:0];
         if (regAddr == `ZLI_A_TSLO) tsLo_r <= regWdata;
         if (regAddr == `ZLI_A_TSHI) tsHi_r <= regWdata;
         if (regAddr == `ZLI_A_LEAD) lead_r <= regWdata;
         if (regAddr == `ZLI_A_SESS) sess_r <= regWdata[15:0];
      end
   end

   // software seeds the sequence with a random start value
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         seq_r <= 16'h0000;
         seqOn_r <= 1'b0;
      end else if (regWr && regAddr == `ZLI_A_SEQ && !busy) begin
         seq_r <= regWdata[15:0];
         seqOn_r <= regWdata[`ZLI_SEQ_ON_BIT];
      end else if (step && txLast) begin
         seq_r <= seq_r + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rej_r <= 32'h0000_0000;
      end else if (pushBad) begin
         rej_r <= rej_r + 32'h0000_0001;
      end
   end

   wire [31:0] statWord = {22'h00_0000, full, busy, {(8 - CW){1'b0}}, cnt_r};
   wire [31:0] rdMux = (regAddr == `ZLI_A_STAT) ? statWord :
                       (regAddr == `ZLI_A_REJ) ? rej_r :
                       (regAddr == `ZLI_A_LEAD) ? lead_r :
                       (regAddr == `ZLI_A_SEQ) ? {15'h0000, seqOn_r, seq_r} :
                       (regAddr == `ZLI_A_SESS) ? {16'h0000, sess_r} :
                       (regAddr == `ZLI_A_MSG) ? {16'h0000, msgA_r} :
                       (regAddr == `ZLI_A_TSLO) ? tsLo_r :
                       (regAddr == `ZLI_A_TSHI) ? tsHi_r : 32'h0000_0000;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= regRd ? rdMux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pktBytes_r <= 16'h0000;
      end else if (step) begin
         pktBytes_r <= txLast ? 16'h0000 : pktBytes_r + 16'h0001;
      end
   end

   property p_hdrFlags;
      @(posedge sys_clk) disable iff (rst)
      (state_r == ZLI_HDR && byteIdx_r == 4'h0) |-> (txData[7] == 1'b0 && txData[0] == 1'b0);
   endproperty
   a_hdrFlags: assert property (p_hdrFlags) else $error("header flag bit not zero");

   property p_seqFlag;
      @(posedge sys_clk) disable iff (rst)
      (state_r == ZLI_HDR && byteIdx_r == 4'h0) |-> (txData[6] == seqOn_r);
   endproperty
   a_seqFlag: assert property (p_seqFlag) else $error("sequence flag wrong");

   property p_extHdr;
      @(posedge sys_clk) disable iff (rst)
      (state_r == ZLI_HDR && byteIdx_r == 4'h0) |-> (txData[5:4] == 2'b00);
   endproperty
   a_extHdr: assert property (p_extHdr) else $error("extended header not 00");

   property p_count;
      @(posedge sys_clk) disable iff (rst)
      (state_r == ZLI_HDR && byteIdx_r == 4'h1) |-> (txData == {1'b0, 7'(cnt_r)} && cnt_r != '0);
   endproperty
   a_count: assert property (p_count) else $error("message count mismatch");

   property p_length;
      @(posedge sys_clk) disable iff (rst)
      (step && txLast) |->
         (pktBytes_r == 16'(`ZLI_HDR_BYTES + `ZLI_MSG_BYTES * 16'(cnt_r) - 16'h0001));
   endproperty
   a_length: assert property (p_length) else $error("packet length wrong");

   property p_noGap;
      @(posedge sys_clk) disable iff (rst)
      (txValid && !txLast) ##1 1'b1 |-> txValid;
   endproperty
   a_noGap: assert property (p_noGap) else $error("packet broken by idle cycle");

   property p_hold;
      @(posedge sys_clk) disable iff (rst)
      (txValid && !txReady) |=> (txValid && $stable(txData) && $stable(txLast));
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed while stalled");

   property p_symNonzero;
      @(posedge sys_clk) disable iff (rst)
      (state_r == ZLI_BODY && byteIdx_r == 4'h1) |-> (txData != 8'h00);
   endproperty
   a_symNonzero: assert property (p_symNonzero) else $error("zero symbol count sent");

   property p_pad;
      @(posedge sys_clk) disable iff (rst)
      (state_r == ZLI_BODY && byteIdx_r >= 4'hA) |-> (txData == 8'h00);
   endproperty
   a_pad: assert property (p_pad) else $error("reserved pad not zero");

   property p_lead;
      @(posedge sys_clk) disable iff (rst)
      (pushReq && (pushTs < tsNow + {32'h0000_0000, lead_r})) |=>
         (rej_r == $past(rej_r) + 32'h0000_0001);
   endproperty
   a_lead: assert property (p_lead) else $error("message accepted too late");

   property p_order;
      @(posedge sys_clk) disable iff (rst)
      pushOk |=> (lastTs_r[$past(chanIdx)] == $past(pushTs) && cnt_r == $past(cnt_r) + 1'b1);
   endproperty
   a_order: assert property (p_order) else $error("channel order not tracked");

endmodule

//--- bench/zli_node_model.sv
// Purpose: remote node model that takes insertion packets off the byte stream
// Assumes: one byte per accepted beat, fields big-endian, tsNow steady per packet
// Notes: a queued entry retires once tsNow passes its start time
`timescale 1ns/1ps
module zli_node_model
   import zli_pkg::*;
#(
   parameter int SEC_TICKS = 1000,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // packet stream in
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire logic rxLast,
   output logic rxReady,
   // timing, pacing and counts
   input wire logic [63:0] tsNow,
   input wire logic slowMode,
   output logic [31:0] okCnt,
   output logic [31:0] dropCnt,
   output logic [31:0] lossCnt
);
   int seed = 32'h29bc_83d9;
   int rnd;
   int idx;
   logic [95:0] msg;
   logic [15:0] lastSeq;
   logic haveSeq;
   logic [63:0] q[256][$];
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxReady <= 1'b0;
         okCnt <= 32'h0000_0000;
         dropCnt <= 32'h0000_0000;
         lossCnt <= 32'h0000_0000;
         haveSeq = 1'b0;
         idx = 0;
         foreach (q[c]) q[c].delete();
      end else begin
         rnd = $random(seed);
         rxReady <= !slowMode || rnd[0];
         // head entry is popped once tsNow passes its start time
         foreach (q[c]) if (q[c].size() != 0 && q[c][0] < tsNow) void'(q[c].pop_front());
         if (rxValid && rxReady) begin
            // VCCV, ext header and flow selector are shifted through unread; only the seq-valid flag is read
            msg = {msg[87:0], rxData};
            idx = idx + 1;
            // successive valid sequence numbers must step by one
            if (idx == 4 && msg[30]) begin
               if (haveSeq && msg[15:0] != lastSeq + 16'h0001) lossCnt <= lossCnt + 1;
               lastSeq = msg[15:0];
               haveSeq = 1'b1;
            end
            if (idx > 4 && (idx - 4) % 12 == 0) begin
               if (msg[79:16] < tsNow || msg[79:16] - tsNow > SEC_TICKS ||
                   q[msg[95:88]].size() >= DEPTH)
                  dropCnt <= dropCnt + 1;
               else begin
                  q[msg[95:88]].push_back(msg[79:16]);
                  okCnt <= okCnt + 1;
               end
            end
            if (rxLast) idx = 0;
         end
      end
   end
endmodule

//--- bench/zero_load_insertion_scheduler_tb.sv
// Purpose: self-checking bench for the insertion framer
// Assumes: tsNow held still while a packet is on the wire
// Notes: every accepted byte is compared with the bench's own packet image
`timescale 1ns/1ps
`include "zli_consts.svh"
module zero_load_insertion_scheduler_tb
   import zli_pkg::*;
;
   localparam int MSG_MAX = 16;
   localparam int N_CHAN = 4;
   localparam logic [63:0] LEAD = 64'h0000_0000_0000_0010;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic [63:0] tsNow = 64'h0000_0001_FFFF_F000;
   logic [7:0] txData;
   logic txValid;
   logic txLast;
   logic txReady;
   logic [15:0] txSession;
   logic slowMode = 1'b0;
   logic [31:0] okCnt;
   logic [31:0] dropCnt;
   logic [31:0] lossCnt;
   int seed = 32'h29bc_83d9;
   int r;
   int bad_count = 0;
   int num_checks = 0;
   int expRej = 0;
   int expOk = 0;
   int expDrop = 0;
   logic busyNow = 1'b0;
   logic [16:0] seqReg;
   logic [7:0] monByte;
   logic [63:0] newest[N_CHAN] = '{default: 64'h0};
   logic [7:0] rstAddr[6] = '{`ZLI_A_CMD, `ZLI_A_LEAD, `ZLI_A_STAT, `ZLI_A_REJ, `ZLI_A_SESS, 8'h24};
   zli_msg_t pend[$];
   logic [7:0] expQ[$];

   always #4 sys_clk = ~sys_clk;

   zli_framer #(.MSG_MAX(MSG_MAX), .N_CHAN(N_CHAN)) u_dut (.sys_clk, .rst, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata, .tsNow, .txData, .txValid, .txLast, .txReady, .txSession);
   zli_node_model u_node (.sys_clk, .rst, .rxData(txData), .rxValid(txValid), .rxLast(txLast),
      .rxReady(txReady), .tsNow, .slowMode, .okCnt, .dropCnt, .lossCnt);

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regRd <= 1'b0;
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
   endtask
   task automatic idle();
      regWr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      regWr <= 1'b0;
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(posedge sys_clk);
      chk(nm, e, regRdata & m);
   endtask
   // stage one message and push it, predicting whether it is refused
   task automatic push(input logic [7:0] ch, input logic [7:0] ns, input logic [63:0] st);
      if (!busyNow && pend.size() < MSG_MAX && ch < N_CHAN && ns != 8'h00 &&
          st >= tsNow + LEAD && st >= newest[ch]) begin
         pend.push_back('{ch, ns, st});
         newest[ch] = st;
      end else
         expRej++;
      wr(`ZLI_A_MSG, {16'h0000, ns, ch});
      wr(`ZLI_A_TSLO, st[31:0]);
      wr(`ZLI_A_TSHI, st[63:32]);
      wr(`ZLI_A_CMD, 32'h0000_0001);
   endtask
   task automatic send(input int nDrop, input logic hit);
      int n;
      n = pend.size();
      expQ.push_back({1'b0, seqReg[16], 6'h00});
      expQ.push_back({1'b0, 7'(n)});
      expQ.push_back(seqReg[15:8]);
      expQ.push_back(seqReg[7:0]);
      foreach (pend[i]) for (int b = 11; b >= 0; b--) expQ.push_back(8'({pend[i], 16'h0} >> 8 * b));
      pend.delete();
      expOk += n - nDrop;
      expDrop += nDrop;
      wr(`ZLI_A_CMD, 32'h0000_0002);
      if (hit) begin
         busyNow = 1'b1;
         push(8'h00, 8'h01, tsNow + LEAD + 64'h0000_0000_0001_0000);
         wr(`ZLI_A_CMD, 32'h0000_0002);
         busyNow = 1'b0;
      end
      idle();
      repeat (3000) if (expQ.size() != 0 || txValid !== 1'b0) @(posedge sys_clk);
      seqReg[15:0] = seqReg[15:0] + 16'h0001;
      repeat (2) @(posedge sys_clk);
      chk("okCnt", expOk, okCnt);
      chk("dropCnt", expDrop, dropCnt);
      chk("lossCnt", 0, lossCnt);
      rdc("seq", `ZLI_A_SEQ, 32'h0001_FFFF, {15'h0, seqReg});
      rdc("rej", `ZLI_A_REJ, 32'hFFFF_FFFF, expRej);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      if (txValid === 1'b1 && txReady === 1'b1) begin
         monByte = (expQ.size() != 0) ? expQ.pop_front() : ~txData;
         chk("txData", monByte, txData);
         chk("txLast", {63'h0, expQ.size() == 0}, txLast);
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (rstAddr[i]) rdc("reset", rstAddr[i], 32'hFFFF_FFFF, 32'h0000_0000);
      chk("session", 16'h0000, txSession);
      r = $random(seed);
      seqReg = {1'b1, r[31:16]};
      wr(`ZLI_A_SESS, {16'h0000, r[15:0]});
      wr(`ZLI_A_LEAD, LEAD[31:0]);
      wr(`ZLI_A_SEQ, {15'h0, seqReg});
      idle();
      chk("session", r[15:0], txSession);
      rdc("lead", `ZLI_A_LEAD, 32'hFFFF_FFFF, LEAD[31:0]);
      $display("test registers done");
      push(8'h00, 8'h01, tsNow + LEAD);
      for (int k = 0; k < 20; k++) begin
         r = $random(seed);
         push(8'(r[2:0]), (r[4:3] == 2'b00) ? 8'h00 : r[15:8] | 8'h01, tsNow + 64'(r[24:16]));
      end
      idle();
      rdc("stat", `ZLI_A_STAT, 32'h0000_03FF,
          {22'h0, pend.size() == MSG_MAX, 1'b0, 8'(pend.size())});
      slowMode <= 1'b1;
      send(0, 1'b0);
      $display("test random pushes done");
      tsNow <= tsNow + 64'h0000_0000_0000_1000;
      slowMode <= 1'b0;
      idle();
      for (int k = 0; k <= MSG_MAX; k++) push(8'h00, 8'hFF, tsNow + LEAD + 64'(k));
      idle();
      rdc("stat", `ZLI_A_STAT, 32'h0000_03FF, {22'h0, 2'b10, 8'(MSG_MAX)});
      send(0, 1'b0);
      push(8'h00, 8'h01, tsNow + LEAD + 64'h0000_0000_0000_0020);
      idle();
      send(1, 1'b0);
      $display("test full queues done");
      seqReg[16] = 1'b0;
      wr(`ZLI_A_SEQ, {15'h0, seqReg});
      push(8'h01, 8'h02, tsNow + LEAD);
      push(8'h02, 8'h03, tsNow + LEAD + 64'h0000_0000_0000_0800);
      tsNow <= tsNow + LEAD + 64'h0000_0000_0000_0001;
      idle();
      send(2, 1'b0);
      $display("test late and early done");
      push(8'h03, 8'h04, tsNow + LEAD);
      idle();
      slowMode <= 1'b1;
      send(0, 1'b1);
      push(8'h03, 8'h05, tsNow + LEAD);
      wr(`ZLI_A_CMD, 32'h0000_0004);
      pend.delete();
      wr(`ZLI_A_CMD, 32'h0000_0002);
      idle();
      repeat (20) @(posedge sys_clk);
      chk("txValid", 1'b0, txValid);
      rdc("stat", `ZLI_A_STAT, 32'h0000_03FF, 32'h0000_0000);
      $display("test busy and clear done");
      tally_and_finish();
   end
endmodule
